/* bench/framer_asserts.sv */
`timescale 1ns/1ps

// Port-level watch on the framer's register port and interrupt pins.
module framer_asserts (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   input wire logic       irq_pin_one_out,
   input wire logic       irq_pin_one_oe_b,
   input wire logic       irq_pin_two_out,
   input wire logic       irq_pin_two_oe_b
);
   logic       norm_q;
   logic [1:0] idle_q;
   logic [2:0] rec_q;
   logic [1:0] oen_q;
   logic       cmd_w;

   // Command writes seen on the port; pin-control writes are decoded below.
   assign cmd_w = wr_stb && addr == 8'h7E;

   // The pins lag a suspend by two flops, so quiet is demanded later.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         norm_q <= 1'b0;
         idle_q <= 2'b00;
         rec_q  <= 3'b111;
         oen_q  <= 2'b00;
      end else begin
         norm_q <= cmd_w ? (wdata == 8'h11) || (norm_q && wdata != 8'h10)
                         : norm_q;
         idle_q <= norm_q ? 2'b00 : {idle_q[0], 1'b1};
         rec_q  <= {rec_q[1:0], wr_stb && addr == 8'h53};
         oen_q  <= (wr_stb && addr == 8'h53) ? {wdata[7], wdata[3]} : oen_q;
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_rdata_rest: assert property (!rd_stb |=> rdata == 8'h00)
      else $error("rdata not zero after a non-read cycle");
   a_err_spare: assert property (rd_stb && addr == 8'h02 |=>
      rdata[7:2] == 6'h00) else $error("spare error bits set");
   a_len_cap: assert property (rd_stb && addr == 8'h23 |=>
      rdata <= 8'h04) else $error("fill count above capacity");
   a_cmd_blind: assert property (rd_stb && addr == 8'h7E |=>
      rdata == 8'h00) else $error("command port read not zero");
   a_pwr_view: assert property (rd_stb && addr == 8'h03 |=>
      rdata[0] == norm_q) else $error("power status mismatch");
   a_quiet_susp: assert property (idle_q == 2'b11 |->
      !irq_pin_one_out && !irq_pin_two_out) else $error("pin up in suspend");
   a_oe_cause: assert property ($changed({irq_pin_one_oe_b,
      irq_pin_two_oe_b}) |-> rec_q != 3'h0) else $error("oe moved alone");
   a_oe_state: assert property (rec_q == 3'h0 |->
      {irq_pin_two_oe_b, irq_pin_one_oe_b} == ~oen_q) else $error("oe wrong");

   cover property (rd_stb && addr == 8'h24 ##1 rdata == 8'h44);
   cover property ($rose(irq_pin_one_out));
   cover property (cmd_w && wdata == 8'hB0);
endmodule

bind sensor_fifo_framer framer_asserts chk (.clk(clk), .rst_b(rst_b),
   .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .rdata(rdata), .irq_pin_one_out(irq_pin_one_out),
   .irq_pin_one_oe_b(irq_pin_one_oe_b), .irq_pin_two_out(irq_pin_two_out),
   .irq_pin_two_oe_b(irq_pin_two_oe_b));

/* bench/host_bus.sv */
`timescale 1ns/1ps

// Host on the register port; one access per call, launched on edges.
module host_bus (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr_stb,
   output logic            rd_stb
);
   // Idle bus from time zero.
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // Write strobe stands one cycle beside address and data.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps

module tb;
   logic        clk, rst_b, s_vld, upd_go, pin1, lnk, o1, o2, oe1, oe2;
   logic [2:0]  axu;
   logic [7:0]  addr, wdata, rdata, v;
   logic        wr_stb, rd_stb;
   int          fail_count, checks;
   localparam logic [47:0] smp = 48'hA1B2_C3D4_E5F6;
   localparam logic [23:0] stamp = 24'h3C_5A7E;

   host_bus h (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb));
   sensor_fifo_framer DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .sample_valid(s_vld), .sample_data(smp), .axis_update(axu),
      .update_start(upd_go), .sensor_time(stamp), .irq_pin_one_in(pin1),
      .irq_pin_two_in(lnk), .irq_pin_one_out(o1), .irq_pin_one_oe_b(oe1),
      .irq_pin_two_out(o2), .irq_pin_two_oe_b(oe2));

   // Core clock, and a 400 ns link clock of unrelated phase on pin two.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      lnk = 1'b0;
      #7;
      forever #200 lnk = ~lnk;
   end

   task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a, logic [7:0] e);
      h.rd(a, v);
      chk(n, e, v);
   endtask
   // One sample pulse, then time for staging to land.
   task automatic send;
      @(posedge clk) s_vld <= 1'b1;
      @(posedge clk) s_vld <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // Pin one's tag is enabled and high; pin two's tag input stays off.
   task automatic frame(input logic hdr);
      if (hdr) begin
         rchk("header", 8'h24, 8'h85);
      end
      for (int i = 0; i < 6; i++) begin
         rchk("byte", 8'h24, smp[8*i +: 8]);
      end
   endtask
   task automatic drive(input logic [2:0] a, input logic u, logic [1:0] e);
      @(posedge clk) {axu, upd_go} <= {a, u};
      @(posedge clk) {axu, upd_go} <= 4'h0;
      repeat (3) @(posedge clk);
      chk("pins", {6'h00, e}, {6'h00, o2, o1});
   endtask

   task automatic t_stream;
      rchk("fcfg", 8'h47, 8'h10);
      rchk("power", 8'h03, 8'h00);
      rchk("unmapped", 8'h00, 8'h00);
      rchk("cmd", 8'h7E, 8'h00);
      h.wr(8'h7E, 8'h11);
      h.wr(8'h54, 8'h10);
      h.wr(8'h47, 8'h90);
      send;
      rchk("len", 8'h22, 8'h07);
      rchk("len hi", 8'h23, 8'h00);
      frame(1'b1);
      rchk("end", 8'h24, 8'h80);
      send;
      repeat (3) h.rd(8'h24, v);
      rchk("len", 8'h22, 8'h07);
      frame(1'b1);
      h.wr(8'h47, 8'h92);
      send;
      frame(1'b1);
      rchk("time hdr", 8'h24, 8'h44);
      for (int i = 0; i < 3; i++) begin
         rchk("time", 8'h24, stamp[8*i +: 8]);
      end
      rchk("end", 8'h24, 8'h80);
      $display("stream test done");
   endtask
   task automatic t_control;
      h.wr(8'h43, 8'h01);
      h.wr(8'h42, 8'h29);
      send;
      rchk("len", 8'h22, 8'h09);
      rchk("cfg hdr", 8'h24, 8'h48);
      rchk("cfg byte", 8'h24, 8'h0C);
      frame(1'b1);
      send;
      h.wr(8'h7E, 8'hB0);
      rchk("len", 8'h22, 8'h00);
      rchk("fcfg", 8'h47, 8'h92);
      h.wr(8'h47, 8'h93);
      rchk("err", 8'h02, 8'h01);
      send;
      rchk("len", 8'h22, 8'h00);
      h.wr(8'h47, 8'h80);
      send;
      rchk("len", 8'h22, 8'h06);
      frame(1'b0);
      rchk("end", 8'h24, 8'h80);
      send;
      h.wr(8'h47, 8'h90);
      rchk("len", 8'h22, 8'h00);
      $display("control test done");
   endtask
   task automatic t_irq;
      h.wr(8'h56, 8'h11);
      h.wr(8'h53, 8'h88);
      drive(3'b011, 1'b0, 2'b00);
      drive(3'b100, 1'b0, 2'b11);
      chk("oe", 8'h00, {7'h00, oe1});
      chk("oe2", 8'h00, {7'h00, oe2});
      rchk("data", 8'h12, smp[7:0]);
      drive(3'b000, 1'b0, 2'b00);
      drive(3'b111, 1'b0, 2'b11);
      drive(3'b000, 1'b1, 2'b00);
      h.wr(8'h7E, 8'h10);
      drive(3'b111, 1'b0, 2'b00);
      $display("interrupt test done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Reset for six cycles, then the scenarios in order.
   initial begin
      {rst_b, s_vld, upd_go, axu, pin1} = 7'h01;
      fail_count = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_stream;
      t_control;
      t_irq;
      wrap_up;
   end
   // A hang counts as a mismatch.
   initial begin
      #2000000;
      fail_count++;
      wrap_up;
   end
endmodule

/* hdl/irq_pins.sv */
`timescale 1ns/1ps

module irq_pins
   import fifo_framer_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_b,
   input  wire logic  ce,
   irq_link_if.pins   link,
   input  wire logic  irq_pin_one_in,
   input  wire logic  irq_pin_two_in,
   output logic       irq_pin_one_out,
   output logic       irq_pin_one_oe_b,
   output logic       irq_pin_two_out,
   output logic       irq_pin_two_oe_b
);

   irq_state_t s_q;
   irq_state_t s_d;
   logic [1:0] pin_in;

   assign pin_in = {irq_pin_two_in, irq_pin_one_in};

   // ---------------------------------------------------------------
   // Per pin: synchroniser, routing, direction and tag source.
   // ---------------------------------------------------------------
   always_comb begin
      logic [2:0] src;
      src = {link.wm, link.full, link.drdy};
      s_d = s_q;
      for (int p = 0; p < 2; p++) begin
         s_d.sync[p] = {s_q.sync[p][1:0], pin_in[p]};
         // Stage 0 only feeds stage 1; stages 1 and 2 must agree.
         if (s_q.sync[p][1] == s_q.sync[p][2]) begin
            s_d.ext[p] = s_q.sync[p][2];
         end
         // Sources never reach a pin while suspended.
         s_d.out[p] = link.normal & |(src & link.map[3*p +: 3]);
         s_d.oe_b[p] = ~link.out_en[p];
         // With both enables set, the tag follows our own output.
         s_d.tag[p] = link.in_en[p] &
                      (link.out_en[p] ? s_q.out[p] : s_q.ext[p]);
      end
   end

   // State register; clock enable low freezes everything.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.oe_b <= 2'h3;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign link.tag = s_q.tag;
   assign irq_pin_one_out = s_q.out[0];
   assign irq_pin_two_out = s_q.out[1];
   assign irq_pin_one_oe_b = s_q.oe_b[0];
   assign irq_pin_two_oe_b = s_q.oe_b[1];

endmodule

/* hdl/sensor_fifo_framer.sv */
`timescale 1ns/1ps
`include "fifo_framer_defs.svh"


module sensor_fifo_framer
   import fifo_framer_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [7:0]  rdata,
   input  wire logic        sample_valid,
   input  wire logic [47:0] sample_data,
   input  wire logic [2:0]  axis_update,
   input  wire logic        update_start,
   input  wire logic [23:0] sensor_time,
   input  wire logic        irq_pin_one_in,
   input  wire logic        irq_pin_two_in,
   output logic             irq_pin_one_out,
   output logic             irq_pin_one_oe_b,
   output logic             irq_pin_two_out,
   output logic             irq_pin_two_oe_b
);

   framer_state_t s_q;
   framer_state_t s_d;

   irq_link_if link ();

   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------

   // Frame length as seen from its first byte.
   function automatic logic [3:0] frame_len(input byte_t hdr,
                                            input logic hmode);
      if (!hmode) begin
         frame_len = `LEN_GYRO;
      end else if (hdr[7:6] == `FT_REGULAR) begin
         frame_len = `LEN_REG_HDR;
      end else begin
         frame_len = `LEN_CTRL;
      end
   endfunction

   function automatic byte_t hdr_byte(input logic [1:0] ft,
                                      input logic [3:0] fp,
                                      input logic [1:0] tg);
      hdr_byte = {ft, fp, tg};
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic.
   // ---------------------------------------------------------------
   always_comb begin
      logic        hmode;
      logic        fifo_err;
      logic        odr_err;
      logic        is_fd;
      logic        do_flush;
      logic        store;
      logic [10:0] add;
      logic [10:0] sub;
      logic [10:0] free;
      rd_phase_t   ph;
      logic [3:0]  fi;
      logic [3:0]  len;
      logic [3:0]  base;
      logic [7:0]  di;
      logic [7:0]  dsmask;
      logic [2:0]  upd_n;
      hmode = s_q.fcfg[`FCFG_HDR_EN];
      fifo_err = (|(s_q.fcfg & `FCFG_RSVD_MASK)) |
                 (!hmode & s_q.fcfg[`FCFG_TIME_EN]);
      odr_err = s_q.gconf[3:0] < `ODR_MIN;
      is_fd = rd_stb && (addr == `A_FDATA);
      do_flush = 1'b0;
      store = 1'b0;
      add = 11'h000;
      sub = 11'h000;
      free = `FIFO_BYTES - s_q.fill;
      ph = s_q.phase;
      fi = s_q.fidx;
      len = 4'h0;
      base = 4'h0;
      di = addr - `A_DATA0;
      dsmask = 8'((9'h001 << s_q.downs[2:0]) - 9'h001);
      upd_n = s_q.upd | axis_update;
      s_d = s_q;
      s_d.rdata = 8'h00;

      // Any access other than a FIFO data read ends a readout burst.
      if (wr_stb || (rd_stb && !is_fd)) begin
         s_d.burst = 1'b0;
      end

      // Register writes.
      if (wr_stb) begin
         case (addr)
            `A_GCONF: begin
               s_d.gconf = wdata;
               s_d.flt_pend = 1'b1;
            end
            `A_GRANGE: begin
               s_d.grange = wdata;
               s_d.rng_pend = 1'b1;
            end
            `A_DOWNS: begin
               s_d.downs = wdata;
               s_d.flt_pend = 1'b1;
            end
            `A_WMARK: s_d.wmark = wdata;
            `A_FCFG: begin
               s_d.fcfg = wdata;
               // Mode switch, or gyro on/off without headers.
               if ((wdata[`FCFG_HDR_EN] != hmode) ||
                   (!hmode && (wdata[`FCFG_GYR_EN] !=
                               s_q.fcfg[`FCFG_GYR_EN]))) begin
                  do_flush = 1'b1;
               end
            end
            `A_OUTCTL: s_d.outctl = wdata;
            `A_INCTL:  s_d.inctl = wdata;
            `A_MAP:    s_d.map = wdata;
            `A_CMD: begin
               if (wdata == `CMD_FLUSH) begin
                  do_flush = 1'b1;
               end else if (wdata == `CMD_NORMAL) begin
                  s_d.normal = 1'b1;
               end else if (wdata == `CMD_SUSPEND) begin
                  s_d.normal = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // Register reads other than the FIFO data port.
      if (rd_stb && !is_fd) begin
         case (addr)
            `A_ERR: s_d.rdata = {6'h00, odr_err, fifo_err};
            `A_PMU: s_d.rdata = {7'h00, s_q.normal};
            `A_LEN0: s_d.rdata = s_q.fill[7:0];
            `A_LEN1: s_d.rdata = {5'h00, s_q.fill[10:8]};
            `A_GCONF: s_d.rdata = s_q.gconf;
            `A_GRANGE: s_d.rdata = s_q.grange;
            `A_DOWNS: s_d.rdata = s_q.downs;
            `A_WMARK: s_d.rdata = s_q.wmark;
            `A_FCFG: s_d.rdata = s_q.fcfg;
            `A_OUTCTL: s_d.rdata = s_q.outctl;
            `A_INCTL: s_d.rdata = s_q.inctl;
            `A_MAP: s_d.rdata = s_q.map;
            default: begin
               if (addr >= `A_DATA0 && addr <= `A_DATA5) begin
                  s_d.rdata = s_q.data[di[2:0]];
               end
            end
         endcase
      end

      // FIFO readout. The committed read pointer moves only once a
      // whole frame has gone out, so a cut-off frame is replayed.
      if (is_fd) begin
         if (!s_q.burst) begin
            ph = (hmode && s_q.skip_pend) ? PH_SKIP : PH_DATA;
            fi = 4'h0;
         end
         s_d.burst = 1'b1;
         case (ph)
            PH_SKIP: begin
               if (fi == 4'h0) begin
                  s_d.rdata = hdr_byte(`FT_CONTROL, `FP_SKIP, 2'b00);
                  s_d.fidx = 4'h1;
               end else begin
                  s_d.rdata = s_q.skip_cnt;
                  s_d.skip_pend = 1'b0;
                  s_d.skip_cnt = 8'h00;
                  s_d.fidx = 4'h0;
                  ph = PH_DATA;
               end
            end
            PH_TIME: begin
               case (fi)
                  4'h1: s_d.rdata = s_q.time_last[7:0];
                  4'h2: s_d.rdata = s_q.time_last[15:8];
                  default: s_d.rdata = s_q.time_last[23:16];
               endcase
               if (fi == 4'h3) begin
                  s_d.time_sent = 1'b1;
                  s_d.fidx = 4'h0;
                  ph = PH_DATA;
               end else begin
                  s_d.fidx = fi + 4'h1;
               end
            end
            default: begin
               if (s_q.fill == 11'h000) begin
                  // Overread: optional time frame, then end marker.
                  if (hmode && s_q.fcfg[`FCFG_TIME_EN] &&
                      !s_q.time_sent) begin
                     s_d.rdata = hdr_byte(`FT_CONTROL, `FP_TIME,
                                          2'b00);
                     s_d.fidx = 4'h1;
                     ph = PH_TIME;
                  end else begin
                     s_d.rdata = `HDR_INVALID;
                  end
               end else begin
                  s_d.rdata = s_q.mem[s_q.rptr + {6'h00, fi}];
                  len = frame_len(s_q.mem[s_q.rptr], hmode);
                  if (fi + 4'h1 == len) begin
                     s_d.rptr = s_q.rptr + {6'h00, len};
                     sub = {7'h00, len};
                     s_d.fidx = 4'h0;
                     s_d.time_last = sensor_time;
                     s_d.time_sent = 1'b0;
                  end else begin
                     s_d.fidx = fi + 4'h1;
                  end
               end
            end
         endcase
         s_d.phase = ph;
      end

      // Sample intake into the data registers and the staging buffer.
      if (sample_valid) begin
         for (int i = 0; i < 6; i++) begin
            s_d.data[i] = sample_data[8*i +: 8];
         end
         s_d.ds_cnt = s_q.ds_cnt + 8'h01;
         store = s_q.normal && s_q.fcfg[`FCFG_GYR_EN] && !fifo_err &&
                 ((s_q.ds_cnt & dsmask) == 8'h00) &&
                 (s_q.stg_len == 4'h0);
      end
      if (store) begin
         if (hmode) begin
            if (s_q.rng_pend || s_q.flt_pend) begin
               s_d.stg[0] = hdr_byte(`FT_CONTROL, `FP_CFG, 2'b00);
               s_d.stg[1] = 8'h00;
               s_d.stg[1][`CFGB_RANGE] = s_q.rng_pend;
               s_d.stg[1][`CFGB_FILT] = s_q.flt_pend;
               // A change written in this very cycle stays pending.
               s_d.rng_pend = wr_stb && (addr == `A_GRANGE);
               s_d.flt_pend = wr_stb && (addr == `A_GCONF || addr == `A_DOWNS);
               base = 4'h2;
            end
            s_d.stg[base] = hdr_byte(`FT_REGULAR, `FP_GYRO,
                                     link.tag);
            base = base + 4'h1;
         end
         // Same byte order as the data registers, headers or not.
         for (int i = 0; i < 6; i++) begin
            s_d.stg[base + 4'(i)] = sample_data[8*i +: 8];
         end
         s_d.stg_len = base + `LEN_GYRO;
         s_d.stg_idx = 4'h0;
      end

      // Drain the staging buffer one byte per cycle. When the frame
      // will not fit, the oldest frame goes instead; the drop waits
      // for a cycle without a read so it never races the readout.
      if (s_q.stg_len != 4'h0) begin
         if (free < {7'h00, s_q.stg_len}) begin
            if (!rd_stb) begin
               len = frame_len(s_q.mem[s_q.rptr], hmode);
               s_d.rptr = s_q.rptr + {6'h00, len};
               sub = {7'h00, len};
               s_d.fidx = 4'h0;
               s_d.burst = 1'b0;
               s_d.skip_pend = hmode;
               if (s_q.skip_cnt != `SKIP_SAT) begin
                  s_d.skip_cnt = s_q.skip_cnt + 8'h01;
               end
            end
         end else begin
            s_d.mem[s_q.wptr + {6'h00, s_q.stg_idx}] =
               s_q.stg[s_q.stg_idx];
            if (s_q.stg_idx + 4'h1 == s_q.stg_len) begin
               // Fill only counts complete frames, control ones too.
               s_d.wptr = s_q.wptr + {6'h00, s_q.stg_len};
               add = {7'h00, s_q.stg_len};
               s_d.stg_len = 4'h0;
            end else begin
               s_d.stg_idx = s_q.stg_idx + 4'h1;
            end
         end
      end

      s_d.fill = s_q.fill + add - sub;

      // Flush keeps every setting and empties only the storage.
      if (do_flush) begin
         s_d.wptr = 10'h000;
         s_d.rptr = 10'h000;
         s_d.fill = 11'h000;
         s_d.fidx = 4'h0;
         s_d.phase = PH_DATA;
         s_d.burst = 1'b0;
         s_d.skip_pend = 1'b0;
         s_d.skip_cnt = 8'h00;
         s_d.stg_len = 4'h0;
         s_d.time_sent = 1'b1;
      end

      // Level flags for the interrupt pins.
      s_d.full = (`FIFO_BYTES - s_d.fill) < `FULL_FREE;
      s_d.wm = s_d.fill > {1'b0, s_d.wmark, 2'b00};

      // Data ready: clear first so a completing update wins.
      if (update_start ||
          (rd_stb && addr >= `A_DATA0 && addr <= `A_DATA5)) begin
         s_d.drdy = 1'b0;
      end
      if (&upd_n) begin
         s_d.drdy = 1'b1;
         s_d.upd = 3'h0;
      end else begin
         s_d.upd = upd_n;
      end
   end

   // ---------------------------------------------------------------
   // State register.
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.fcfg <= `RST_FCFG;
         s_q.gconf <= `RST_GCONF;
         s_q.time_sent <= 1'b1;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;

   // ---------------------------------------------------------------
   // Interrupt pin block.
   // ---------------------------------------------------------------
   assign link.drdy = s_q.drdy;
   assign link.full = s_q.full;
   assign link.wm = s_q.wm;
   assign link.normal = s_q.normal;
   assign link.map = {s_q.map[6:4], s_q.map[2:0]};
   assign link.out_en = {s_q.outctl[`OUT_EN2], s_q.outctl[`OUT_EN1]};
   assign link.in_en = {s_q.inctl[`IN_EN2], s_q.inctl[`IN_EN1]};

   irq_pins u_irq (
      .clk              (clk),
      .rst_b            (rst_b),
      .ce               (ce),
      .link             (link),
      .irq_pin_one_in   (irq_pin_one_in),
      .irq_pin_two_in   (irq_pin_two_in),
      .irq_pin_one_out  (irq_pin_one_out),
      .irq_pin_one_oe_b (irq_pin_one_oe_b),
      .irq_pin_two_out  (irq_pin_two_out),
      .irq_pin_two_oe_b (irq_pin_two_oe_b)
   );

endmodule

/* shared/fifo_framer_defs.svh */
`ifndef FIFO_FRAMER_DEFS_SVH
`define FIFO_FRAMER_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define A_ERR      8'h02
`define A_PMU      8'h03
`define A_DATA0    8'h12
`define A_DATA5    8'h17
`define A_LEN0     8'h22
`define A_LEN1     8'h23
`define A_FDATA    8'h24
`define A_GCONF    8'h42
`define A_GRANGE   8'h43
`define A_DOWNS    8'h45
`define A_WMARK    8'h46
`define A_FCFG     8'h47
`define A_OUTCTL   8'h53
`define A_INCTL    8'h54
`define A_MAP      8'h56
`define A_CMD      8'h7E

// ----------------------------------------------------------------------
// Command opcodes.
// ----------------------------------------------------------------------
`define CMD_FLUSH   8'hB0
`define CMD_NORMAL  8'h11
`define CMD_SUSPEND 8'h10

// ----------------------------------------------------------------------
// Frame header fields and fixed bytes.
// ----------------------------------------------------------------------
`define FT_REGULAR  2'b10
`define FT_CONTROL  2'b01
`define FP_GYRO     4'h1
`define FP_SKIP     4'h0
`define FP_TIME     4'h1
`define FP_CFG      4'h2
`define HDR_INVALID 8'h80
`define SKIP_SAT    8'hFF
`define CFGB_RANGE  3
`define CFGB_FILT   2

// ----------------------------------------------------------------------
// Configuration fields, reset values and sizes.
// ----------------------------------------------------------------------
`define FCFG_GYR_EN    7
`define FCFG_HDR_EN    4
`define FCFG_TIME_EN   1
`define FCFG_RSVD_MASK 8'h6D
`define ODR_MIN        4'h6
`define ERR_FIFO       0
`define ERR_ODR        1
`define OUT_EN1        3
`define OUT_EN2        7
`define IN_EN1         4
`define IN_EN2         5
`define RST_FCFG       8'h10
`define RST_GCONF      8'h28
`define FIFO_BYTES     11'h400
`define FULL_FREE      11'h00E
`define LEN_GYRO       4'h6
`define LEN_REG_HDR    4'h7
`define LEN_CTRL       4'h2

`endif

/* shared/fifo_framer_pkg.sv */
`include "fifo_framer_defs.svh"

package fifo_framer_pkg;

   // Readout phases, Gray coded along data -> skip -> time.
   typedef enum logic [1:0] {
      PH_DATA = 2'b00,
      PH_SKIP = 2'b01,
      PH_TIME = 2'b11
   } rd_phase_t;

   typedef logic [7:0] byte_t;

   typedef struct packed {
      byte_t [1023:0] mem;
      logic [9:0]     wptr;
      logic [9:0]     rptr;
      logic [10:0]    fill;
      logic [3:0]     fidx;
      rd_phase_t      phase;
      logic           burst;
      logic           skip_pend;
      byte_t          skip_cnt;
      logic           time_sent;
      logic [23:0]    time_last;
      byte_t [8:0]    stg;
      logic [3:0]     stg_len;
      logic [3:0]     stg_idx;
      byte_t          wmark;
      byte_t          fcfg;
      byte_t          downs;
      byte_t          gconf;
      byte_t          grange;
      byte_t          map;
      byte_t          outctl;
      byte_t          inctl;
      logic           normal;
      byte_t [5:0]    data;
      logic [2:0]     upd;
      logic           drdy;
      byte_t          ds_cnt;
      logic           rng_pend;
      logic           flt_pend;
      logic           full;
      logic           wm;
      byte_t          rdata;
   } framer_state_t;

   typedef struct packed {
      logic [1:0][2:0] sync;
      logic [1:0]      ext;
      logic [1:0]      out;
      logic [1:0]      oe_b;
      logic [1:0]      tag;
   } irq_state_t;

endpackage

/* shared/irq_link_if.sv */
`timescale 1ns/1ps

// Interrupt sources and pin controls from the framer, tags back.
interface irq_link_if;
   logic       drdy;
   logic       full;
   logic       wm;
   logic       normal;
   logic [5:0] map;
   logic [1:0] out_en;
   logic [1:0] in_en;
   logic [1:0] tag;

   modport core (output drdy, full, wm, normal, map, out_en, in_en,
                 input tag);
   modport pins (input drdy, full, wm, normal, map, out_en, in_en,
                 output tag);
endinterface
